// [stcu_defines.vh]
`ifndef STCU_DEFINES_VH
`define STCU_DEFINES_VH
// clock and baud timing
`define STCU_CLK_HZ        20000000
`define STCU_OVERSAMPLE    16
// baud select codes
`define STCU_BAUD_110      3'h0
`define STCU_BAUD_600      3'h1
`define STCU_BAUD_1200     3'h2
`define STCU_BAUD_2400     3'h3
`define STCU_BAUD_4800     3'h4
`define STCU_BAUD_9600     3'h5
// control states
`define STCU_ST_INACTIVE   3'h0
`define STCU_ST_EXEC_IN    3'h1
`define STCU_ST_EXCH_IN    3'h2
`define STCU_ST_EXEC_OUT   3'h3
`define STCU_ST_EXCH_OUT   3'h4
`define STCU_ST_WAIT       3'h5
// status word bit positions
`define STCU_STAT_CHERR    0
`define STCU_STAT_HALT     1
`define STCU_STAT_OPER     2
`define STCU_STAT_INACC    3
`define STCU_STAT_ECHO     4
`define STCU_STAT_RDY      5
// bit index of the start option loopback bit on the host data lines
`define STCU_START_OPT_BIT 5
`endif

// [stcu_serial_terminal_control_unit.v]
module stcu_serial_terminal_control_unit #(
   parameter OVS = 16
) (
   input  wire       mclk_i,
   input  wire       sys_rst_i,
   input  wire       channel_start_cmd_i,
   input  wire       channel_halt_cmd_i,
   input  wire       start_dir_in_i,
   input  wire       start_option_loopback_bit_i,
   input  wire       output_transfer_command_i,
   input  wire       input_transfer_command_i,
   input  wire       status_read_command_i,
   input  wire [7:0] host_data_i,
   input  wire       microcode_loopback_strobe_i,
   input  wire       status_clear_strobe_i,
   input  wire       loopback_select_input_i,
   input  wire [2:0] baud_select_i,
   input  wire       stop_bit_count_select_i,
   input  wire       parity_disable_input_i,
   input  wire       parity_length_input_i,
   input  wire       parity_polarity_input_i,
   input  wire       ready_force_jumper_i,
   input  wire       serial_in_line_i,
   input  wire       terminal_operable_line_i,
   input  wire       terminal_ready_line_i,
   output reg  [7:0] host_data_o,
   output wire       serial_out_line_o,
   output wire       operable_mirror_line_o,
   output wire       host_powered_line_a_o,
   output wire       host_powered_line_b_o,
   output reg        serial_interrupt_request_o,
   output reg        parity_error_signal_o,
   output wire       transmit_data_strobe_o,
   output wire [2:0] control_state_o
);
`include "stcu_defines.vh"

   // three-stage synchronisers on pins; change counts when stages two and three agree
   reg  [2:0] rxd_s_q, opr_s_q, rdy_s_q;
   reg        rxd_q, opr_q, rdy_q;
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rxd_s_q <= 3'h7;
         opr_s_q <= 3'h0;
         rdy_s_q <= 3'h0;
         rxd_q   <= 1'b1;
         opr_q   <= 1'b0;
         rdy_q   <= 1'b0;
      end else begin
         rxd_s_q <= {rxd_s_q[1:0], serial_in_line_i};
         opr_s_q <= {opr_s_q[1:0], terminal_operable_line_i};
         rdy_s_q <= {rdy_s_q[1:0], terminal_ready_line_i};
         if (rxd_s_q[1] == rxd_s_q[2]) rxd_q <= rxd_s_q[2];
         if (opr_s_q[1] == opr_s_q[2]) opr_q <= opr_s_q[2];
         if (rdy_s_q[1] == rdy_s_q[2]) rdy_q <= rdy_s_q[2];
      end
   end
   wire terminal_ready_signal = rdy_q | ready_force_jumper_i;

   // pin mirror and constant powered indications
   assign operable_mirror_line_o = opr_q;
   assign host_powered_line_a_o  = 1'b1;
   assign host_powered_line_b_o  = 1'b1;

   // baud divider: oversample tick at sixteen times the selected rate
   reg [31:0] div_max;
   always @* begin
      case (baud_select_i)
         `STCU_BAUD_110:  div_max = `STCU_CLK_HZ / (110 * OVS) - 1;
         `STCU_BAUD_600:  div_max = `STCU_CLK_HZ / (600 * OVS) - 1;
         `STCU_BAUD_1200: div_max = `STCU_CLK_HZ / (1200 * OVS) - 1;
         `STCU_BAUD_2400: div_max = `STCU_CLK_HZ / (2400 * OVS) - 1;
         `STCU_BAUD_4800: div_max = `STCU_CLK_HZ / (4800 * OVS) - 1;
         default:         div_max = `STCU_CLK_HZ / (9600 * OVS) - 1;
      endcase
   end
   reg [15:0] div_q;
   reg        baud_sync_flop_q;
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         div_q            <= 16'h0000;
         baud_sync_flop_q <= 1'b0;
      end else begin
         if (div_q >= div_max[15:0]) div_q <= 16'h0000;
         else div_q <= div_q + 16'h0001;
         baud_sync_flop_q <= (div_q >= div_max[15:0]);
      end
   end
   wire tick = baud_sync_flop_q;  // transmitter and receiver clock input

   // framing configuration
   wire par_en  = ~parity_disable_input_i & ~parity_length_input_i;
   wire odd_par = parity_polarity_input_i;

   // two-entry transmit buffer
   reg [7:0] buf_q [0:1];
   reg [1:0] cnt_q;
   reg       wp_q, rp_q;
   wire      tx_pop;
   wire      buf_ready = (cnt_q != 2'h2);
   wire      buf_valid = (cnt_q != 2'h0);
   wire      tx_push;
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_q <= 2'h0;
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         buf_q[0] <= 8'h00;
         buf_q[1] <= 8'h00;
      end else begin
         if (tx_push) begin
            buf_q[wp_q] <= host_data_i;
            wp_q <= ~wp_q;
         end
         if (tx_pop) rp_q <= ~rp_q;
         cnt_q <= cnt_q + {1'b0, tx_push} - {1'b0, tx_pop};
      end
   end

   // transmitter: shift register with start, eight data (seven data and parity when parity is on), stop bits
   reg [3:0] tx_ph_q;
   reg [3:0] tx_bit_q;
   reg [9:0] tx_sh_q;
   reg       tx_busy_q, tx_line_q;
   wire [7:0] tx_word = buf_q[rp_q];
   wire [7:0] tx_char = par_en ?
      {(^tx_word[7:1]) ^ odd_par, tx_word[7:1]} :
      {tx_word[0], tx_word[1], tx_word[2], tx_word[3],
       tx_word[4], tx_word[5], tx_word[6], tx_word[7]};
   assign tx_pop = ~tx_busy_q & buf_valid & terminal_ready_signal & tick;
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_ph_q   <= 4'h0;
         tx_bit_q  <= 4'h0;
         tx_sh_q   <= 10'h3ff;
         tx_busy_q <= 1'b0;
         tx_line_q <= 1'b1;
      end else if (tx_pop) begin
         tx_sh_q   <= {2'h3, tx_char};
         tx_line_q <= 1'b0;                                     // start bit
         tx_busy_q <= 1'b1;
         tx_ph_q   <= 4'h0;
         tx_bit_q  <= 4'h0;
      end else if (tx_busy_q && tick) begin
         tx_ph_q <= tx_ph_q + 4'h1;
         if (tx_ph_q == 4'hf) begin
            if (tx_bit_q == (stop_bit_count_select_i ? 4'ha : 4'h9)) begin
               tx_busy_q <= 1'b0;
               tx_line_q <= 1'b1;                               // idle high
            end else begin
               tx_line_q <= tx_sh_q[0];
               tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
               tx_bit_q  <= tx_bit_q + 4'h1;
            end
         end
      end
   end

   // receiver: start edge detect, mid-bit sampling, framing stripped
   reg [3:0] rx_ph_q;
   reg [3:0] rx_bit_q;
   reg [7:0] rx_sh_q;
   reg       rx_busy_q, rx_done_q;
   reg [7:0] rx_data_q;
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_ph_q   <= 4'h0;
         rx_bit_q  <= 4'h0;
         rx_sh_q   <= 8'h00;
         rx_busy_q <= 1'b0;
         rx_done_q <= 1'b0;
         rx_data_q <= 8'h00;
         parity_error_signal_o <= 1'b0;
      end else begin
         rx_done_q <= 1'b0;
         if (!rx_busy_q) begin
            if (tick && !rxd_q) begin
               rx_busy_q <= 1'b1;
               rx_ph_q   <= 4'h1;
               rx_bit_q  <= 4'h0;
            end
         end else if (tick) begin
            rx_ph_q <= rx_ph_q + 4'h1;
            if (rx_ph_q == 4'h8) begin
               if (rx_bit_q == 4'h0 && rxd_q) rx_busy_q <= 1'b0;   // false start
               else if (rx_bit_q == 4'h9) begin                 // stop bit
                  rx_busy_q <= 1'b0;
                  rx_done_q <= 1'b1;
                  rx_data_q <= par_en ? {rx_sh_q[6:0], 1'b0} :
                     {rx_sh_q[0], rx_sh_q[1], rx_sh_q[2], rx_sh_q[3],
                      rx_sh_q[4], rx_sh_q[5], rx_sh_q[6], rx_sh_q[7]};
                  parity_error_signal_o <= par_en &&
                     ((^rx_sh_q[6:0]) ^ odd_par) != rx_sh_q[7];
               end else begin
                  if (rx_bit_q != 4'h0) rx_sh_q <= {rxd_q, rx_sh_q[7:1]};
                  rx_bit_q <= rx_bit_q + 4'h1;
               end
            end
         end
      end
   end

   // echo path: loopback select low in echo mode copies serial in to out
   reg loopback_request_flop_q, echo_q, tds_q;
   wire echo_path = echo_q & loopback_request_flop_q & ~loopback_select_input_i;
   assign serial_out_line_o = echo_path ? rxd_q : tx_line_q;
   assign transmit_data_strobe_o = tds_q;

   // control state machine
   reg [2:0] st_q;
   reg       character_error_flop_q, halt_request_flop_q, input_accepted_flop_q;
   // parity error at end of a character while the channel is active
   wire      perr_hit = rx_done_q & parity_error_signal_o & (st_q != `STCU_ST_INACTIVE);
   assign control_state_o = st_q;
   assign tx_push = (st_q == `STCU_ST_EXCH_OUT) & output_transfer_command_i & buf_ready;
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q <= `STCU_ST_INACTIVE;
         character_error_flop_q  <= 1'b0;
         halt_request_flop_q     <= 1'b0;
         input_accepted_flop_q   <= 1'b0;
         loopback_request_flop_q <= 1'b0;
         echo_q <= 1'b0;
         tds_q  <= 1'b0;
         serial_interrupt_request_o <= 1'b0;
      end else begin
         // transmit data strobe copies the microcode step strobe one cycle later
         tds_q <= microcode_loopback_strobe_i;
         if (input_transfer_command_i && st_q == `STCU_ST_EXCH_IN)
            input_accepted_flop_q <= 1'b1;
         else if (st_q == `STCU_ST_WAIT && status_clear_strobe_i) begin
            input_accepted_flop_q <= 1'b0;
            echo_q <= 1'b0;
         end
         // set comes last so a strobe beats a clear in the same cycle
         if (microcode_loopback_strobe_i) echo_q <= 1'b1;
         if (channel_start_cmd_i) begin
            loopback_request_flop_q <= host_data_i[`STCU_START_OPT_BIT];
            character_error_flop_q  <= perr_hit;                // error beats the clear
            halt_request_flop_q     <= perr_hit;
            if (!opr_q) st_q <= `STCU_ST_WAIT;
            else if (start_dir_in_i) st_q <= `STCU_ST_EXEC_IN;
            else st_q <= `STCU_ST_EXEC_OUT;
         end else if (perr_hit) begin
            character_error_flop_q <= 1'b1;
            halt_request_flop_q    <= 1'b1;
            st_q <= `STCU_ST_WAIT;
         end else if (channel_halt_cmd_i && st_q != `STCU_ST_INACTIVE) begin
            st_q <= `STCU_ST_WAIT;
         end else begin
            case (st_q)
               `STCU_ST_EXEC_IN:  if (rx_done_q) st_q <= `STCU_ST_EXCH_IN;
               `STCU_ST_EXCH_IN:  if (input_transfer_command_i) st_q <= `STCU_ST_EXEC_IN;
               `STCU_ST_EXEC_OUT: if (!tx_busy_q && !buf_valid && terminal_ready_signal)
                                     st_q <= `STCU_ST_EXCH_OUT;
               `STCU_ST_EXCH_OUT: if (tx_push) st_q <= `STCU_ST_EXEC_OUT;
               default:           st_q <= st_q;
            endcase
         end
         // interrupt for each transfer request and in wait status
         serial_interrupt_request_o <= (st_q == `STCU_ST_EXCH_IN) ||
            (st_q == `STCU_ST_EXCH_OUT) || (st_q == `STCU_ST_WAIT);
      end
   end

   // host input data mux: status word or received character
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) host_data_o <= 8'h00;
      else if (status_read_command_i)
         host_data_o <= {2'h0, terminal_ready_signal, loopback_request_flop_q,
                         input_accepted_flop_q, opr_q, halt_request_flop_q,
                         character_error_flop_q};
      else host_data_o <= rx_data_q;
   end

endmodule // stcu_serial_terminal_control_unit

// [stcu_monitor.sv]
`include "stcu_defines.vh"
module stcu_monitor (
   input wire logic       mclk_i,
   input wire logic       sys_rst_i,
   input wire logic       channel_start_cmd_i,
   input wire logic       microcode_loopback_strobe_i,
   input wire logic       terminal_operable_line_i,
   input wire logic       serial_out_line_o,
   input wire logic       operable_mirror_line_o,
   input wire logic       host_powered_line_a_o,
   input wire logic       host_powered_line_b_o,
   input wire logic       serial_interrupt_request_o,
   input wire logic       parity_error_signal_o,
   input wire logic       transmit_data_strobe_o,
   input wire logic [2:0] control_state_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);
   // static lines and mirrors
   a_powered_high: assert property (host_powered_line_a_o && host_powered_line_b_o)
      else $error("powered lines low");
   a_mirror_high: assert property (terminal_operable_line_i[*5] |-> operable_mirror_line_o)
      else $error("mirror low while operable");
   a_mirror_low: assert property (!terminal_operable_line_i[*5] |-> !operable_mirror_line_o)
      else $error("mirror high while inoperable");
   // start outcome follows the operable line
   a_start_exec: assert property (terminal_operable_line_i[*5] ##0 channel_start_cmd_i |->
      ##[1:3] (control_state_o != `STCU_ST_INACTIVE && control_state_o != `STCU_ST_WAIT))
      else $error("start did not execute");
   a_start_wait: assert property (!terminal_operable_line_i[*5] ##0 channel_start_cmd_i |->
      ##[1:3] control_state_o == `STCU_ST_WAIT) else $error("start did not wait");
   // interrupt tracks the state one cycle late
   a_irq_wait: assert property ((control_state_o == `STCU_ST_WAIT)[*2] |->
      serial_interrupt_request_o) else $error("no interrupt in wait");
   a_irq_exec: assert property ((control_state_o == `STCU_ST_EXEC_IN)[*2] |->
      !serial_interrupt_request_o) else $error("interrupt in execute");
   a_idle_inactive: assert property (control_state_o == `STCU_ST_INACTIVE |->
      serial_out_line_o) else $error("line not idle");
   a_perr_wait: assert property ($rose(parity_error_signal_o) |->
      ##[0:3] control_state_o == `STCU_ST_WAIT) else $error("parity error without wait");
   a_strobe_follow: assert property (microcode_loopback_strobe_i |=>
      transmit_data_strobe_o) else $error("transmit strobe missing");
   // main scenarios reached
   c_tx_exch: cover property (control_state_o == `STCU_ST_EXCH_OUT);
   c_rx_exch: cover property (control_state_o == `STCU_ST_EXCH_IN);
   c_perr: cover property ($rose(parity_error_signal_o));
endmodule // stcu_monitor
bind stcu_serial_terminal_control_unit stcu_monitor i_stcu_monitor (
   .mclk_i, .sys_rst_i, .channel_start_cmd_i, .microcode_loopback_strobe_i,
   .terminal_operable_line_i, .serial_out_line_o, .operable_mirror_line_o,
   .host_powered_line_a_o, .host_powered_line_b_o, .serial_interrupt_request_o,
   .parity_error_signal_o, .transmit_data_strobe_o, .control_state_o);

// [stcu_terminal_model.sv]
module stcu_terminal_model #(
   parameter int BIT_NS = 104167
) (
   input  wire logic serial_out_line_i,
   output logic      serial_in_line_o,
   output logic      terminal_operable_line_o,
   output logic      terminal_ready_line_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic power_on = 1'b0;
   logic ready_on = 1'b0;
   // operable only while switched on, ready only when a character fits
   assign terminal_operable_line_o = power_on;
   assign terminal_ready_line_o = power_on & ready_on;
   initial serial_in_line_o = 1'b1;
   // one character toward the unit, w[0] first on the wire, one stop bit
   task send(input logic [7:0] w);
      int k;
      serial_in_line_o = 1'b0;
      #BIT_NS;
      for (k = 0; k < 8; k++) begin
         serial_in_line_o = w[k];
         #BIT_NS;
      end
      serial_in_line_o = 1'b1;
      #BIT_NS;
   endtask
   // bounded hunt for the start edge, then mid-bit samples of the frame
   task recv(output logic [10:0] f);
      int k;
      for (k = 0; k < 400 && serial_out_line_i; k++) #500;
      #(BIT_NS / 2);
      for (k = 0; k < 11; k++) begin
         f[k] = serial_out_line_i;
         #BIT_NS;
      end
   endtask
endmodule // stcu_terminal_model

// [stcu_tb.sv]
`include "stcu_defines.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk_i = 1'b0, sys_rst_i = 1'b1, channel_start_cmd_i = 1'b0;
   logic        channel_halt_cmd_i = 1'b0, start_dir_in_i = 1'b0;
   logic        output_transfer_command_i = 1'b0, input_transfer_command_i = 1'b0;
   logic        status_read_command_i = 1'b0, microcode_loopback_strobe_i = 1'b0;
   logic        status_clear_strobe_i = 1'b0, stop_bit_count_select_i = 1'b1;
   logic        parity_disable_input_i = 1'b1, parity_length_input_i = 1'b1;
   logic        parity_polarity_input_i = 1'b0, loopback_select_input_i = 1'b1;
   logic [7:0]  host_data_i = 8'h00;
   logic        serial_in_line_i, terminal_operable_line_i, terminal_ready_line_i;
   logic [7:0]  host_data_o;
   logic [2:0]  control_state_o;
   logic        serial_out_line_o, operable_mirror_line_o, host_powered_line_a_o;
   logic        host_powered_line_b_o, serial_interrupt_request_o, parity_error_signal_o;
   logic        transmit_data_strobe_o;
   logic [10:0] frame;
   int          bad_count = 0;
   int          cmp_count = 0;
   stcu_serial_terminal_control_unit i_stcu_serial_terminal_control_unit (
      .mclk_i, .sys_rst_i, .channel_start_cmd_i, .channel_halt_cmd_i, .start_dir_in_i,
      .start_option_loopback_bit_i(1'b0), .output_transfer_command_i,
      .input_transfer_command_i, .status_read_command_i, .host_data_i,
      .microcode_loopback_strobe_i, .status_clear_strobe_i, .loopback_select_input_i,
      .baud_select_i(`STCU_BAUD_9600), .stop_bit_count_select_i, .parity_disable_input_i,
      .parity_length_input_i, .parity_polarity_input_i, .ready_force_jumper_i(1'b0),
      .serial_in_line_i, .terminal_operable_line_i, .terminal_ready_line_i, .host_data_o,
      .serial_out_line_o, .operable_mirror_line_o, .host_powered_line_a_o,
      .host_powered_line_b_o, .serial_interrupt_request_o, .parity_error_signal_o,
      .transmit_data_strobe_o, .control_state_o);
   stcu_terminal_model i_stcu_terminal_model (
      .serial_out_line_i(serial_out_line_o), .serial_in_line_o(serial_in_line_i),
      .terminal_operable_line_o(terminal_operable_line_i),
      .terminal_ready_line_o(terminal_ready_line_i));
   // 20 MHz clock
   initial forever #25 mclk_i = ~mclk_i;
   task cyc(input int n);
      repeat (n) @(negedge mclk_i);
   endtask
   task chk(input string nm, input logic [10:0] e, input logic [10:0] s);
      cmp_count++;
      if (s !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, s);
         bad_count++;
      end
   endtask
   task end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // bounded wait for a control state; a miss ends the run
   task wst(input logic [2:0] s, input int n);
      int k;
      for (k = 0; k < n && control_state_o !== s; k++) cyc(1);
      chk("state", 11'(s), 11'(control_state_o));
      if (control_state_o !== s) end_of_test();
   endtask
   task automatic pulse(ref logic p);
      p = 1'b1;
      cyc(1);
      p = 1'b0;
   endtask
   // reset with new framing jumpers
   task restart(input logic par, input logic odd, input logic two);
      sys_rst_i = 1'b1;
      {parity_disable_input_i, parity_length_input_i} = {2{!par}};
      parity_polarity_input_i = odd;
      stop_bit_count_select_i = two;
      cyc(12);
      sys_rst_i = 1'b0;
      // let the pin synchronisers settle before the first command
      cyc(6);
   endtask
   task start(input logic din);
      start_dir_in_i = din;
      host_data_i = 8'h00;
      pulse(channel_start_cmd_i);
   endtask
   task stat(input logic [7:0] e, input logic [7:0] m);
      status_read_command_i = 1'b1;
      cyc(2);
      chk("status", 11'(e), 11'(host_data_o & m));
      status_read_command_i = 1'b0;
   endtask
   task s_idle();
      chk("powered", 11'h3, 11'({host_powered_line_a_o, host_powered_line_b_o}));
      chk("idle", 11'h1, 11'(serial_out_line_o));
      pulse(microcode_loopback_strobe_i);
      chk("tds", 11'h1, 11'(transmit_data_strobe_o));
      start(1'b0);
      wst(`STCU_ST_WAIT, 4);
      cyc(2);
      chk("irq", 11'h1, 11'(serial_interrupt_request_o));
      chk("mirror", 11'h0, 11'(operable_mirror_line_o));
   endtask
   // output character, ready held back at first
   task s_tx(input logic [7:0] d, input logic [10:0] e);
      i_stcu_terminal_model.power_on = 1'b1;
      i_stcu_terminal_model.ready_on = 1'b0;
      cyc(10);
      chk("mirror", 11'h1, 11'(operable_mirror_line_o));
      start(1'b0);
      cyc(8);
      chk("state", 11'(`STCU_ST_EXEC_OUT), 11'(control_state_o));
      i_stcu_terminal_model.ready_on = 1'b1;
      wst(`STCU_ST_EXCH_OUT, 20);
      cyc(1);
      chk("irq", 11'h1, 11'(serial_interrupt_request_o));
      host_data_i = d;
      pulse(output_transfer_command_i);
      i_stcu_terminal_model.recv(frame);
      chk("frame", e, frame);
   endtask
   // input character; with echo the model also listens on the out line
   task s_rx(input logic [7:0] w, input logic [2:0] s, input logic echo);
      start_dir_in_i = 1'b1;
      loopback_select_input_i = !echo;
      host_data_i = {2'h0, echo, 5'h00};
      pulse(channel_start_cmd_i);
      pulse(microcode_loopback_strobe_i);
      wst(`STCU_ST_EXEC_IN, 10);
      if (echo) fork
         i_stcu_terminal_model.send(w);
         i_stcu_terminal_model.recv(frame);
      join
      else i_stcu_terminal_model.send(w);
      wst(s, 400);
      if (echo) chk("echo", {2'b11, w, 1'b0}, frame);
      loopback_select_input_i = 1'b1;
   endtask
   initial begin
      cyc(12);
      sys_rst_i = 1'b0;
      cyc(1);
      s_idle();
      restart(1'b0, 1'b0, 1'b1);
      s_tx(8'ha5, {2'b11, 8'ha5, 1'b0});
      restart(1'b1, 1'b1, 1'b0);
      s_tx(8'hfe, {2'b11, 8'h7f, 1'b0});
      restart(1'b0, 1'b0, 1'b0);
      s_rx(8'h81, `STCU_ST_EXCH_IN, 1'b0);
      chk("rxdata", 11'h81, 11'(host_data_o));
      pulse(input_transfer_command_i);
      stat(8'h2c, 8'h3f);
      pulse(channel_halt_cmd_i);
      wst(`STCU_ST_WAIT, 4);
      pulse(status_clear_strobe_i);
      stat(8'h24, 8'h3c);
      restart(1'b1, 1'b1, 1'b0);
      s_rx(8'hff, `STCU_ST_WAIT, 1'b1);
      chk("perr", 11'h1, 11'(parity_error_signal_o));
      stat(8'h13, 8'h13);
      end_of_test();
   end
endmodule // testbench
